/* src/tdp_access_port.v */
`timescale 1ns/1ps
`include "tdp_consts.vh"

// small synchronous fifo with valid/ready on both sides
module tdp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // tdp_fifo

// How it works
// - request is active low; held high when the port is unused
// - 26-bit byte address; only bits 11:0 are used: 11:2 pick one of 1024 words (4 kilobytes), 1:0 the write byte lanes
// - direction 0 read, 1 write; write size byte, half, word, reserved
// - reads ignore size and always return a full 32-bit word
// - stall request from the master stalls the core for dma ram use
// - stall request and trace buffer full give the same core stall
// - stall ack is high while the core is stalled
module tdp_access_port (
    input  wire                   SYS_CLK,
    input  wire                   RESET,
    input  wire                   DMA_PORT_ENABLE,
    input  wire                   DMA_REQUEST_LOW_N,
    input  wire [`TDP_ADDR_W-1:0] DMA_ADDR_IN,
    input  wire                   DMA_WRITE_SELECT,
    input  wire [1:0]             DMA_ACCESS_SIZE,
    input  wire [`TDP_DATA_W-1:0] DMA_WRITE_WORD,
    input  wire                   DMA_STALL_REQUEST,
    input  wire                   TRACE_BUFFER_FULL,
    input  wire                   CORE_RAM_REQ,
    input  wire                   CORE_RAM_WRITE,
    input  wire [`TDP_RAM_AW-1:0] CORE_RAM_ADDR,
    input  wire [3:0]             CORE_RAM_BE,
    input  wire [`TDP_DATA_W-1:0] CORE_RAM_WDATA,
    output reg                    REQ_ACCEPT,
    output reg                    DMA_STALL_ACK,
    output reg  [`TDP_DATA_W-1:0] DMA_READ_WORD,
    output reg                    DMA_READ_VALID,
    output reg                    CORE_STALL,
    output reg  [`TDP_DATA_W-1:0] CORE_RAM_RDATA
);
    reg  [`TDP_DATA_W-1:0] ram [0:`TDP_RAM_DEPTH-1];
    wire                   req_take;
    wire                   fifo_in_ready;
    wire [`TDP_REQ_W-1:0]  fifo_in_data;
    wire                   fifo_out_valid;
    wire [`TDP_REQ_W-1:0]  fifo_out_data;
    wire                   dma_go;
    wire                   hd_write;
    wire [1:0]             hd_size;
    wire [`TDP_ADDR_W-1:0] hd_addr;
    wire [`TDP_DATA_W-1:0] hd_data;
    wire [`TDP_RAM_AW-1:0] hd_index;
    wire [3:0]             hd_be;
    wire [`TDP_DATA_W-1:0] hd_wmask;
    wire [`TDP_DATA_W-1:0] hd_wdata;
    wire                   stall_cause;
    wire                   core_go;
    wire [`TDP_DATA_W-1:0] core_wmask;

    // byte enables from size and low address; reserved size writes nothing
    function [3:0] size_be;
        input [1:0] size;
        input [1:0] lo;
        begin
            case (size)
                `TDP_SIZE_BYTE: size_be = 4'h1 << lo;
                `TDP_SIZE_HALF: size_be = lo[1] ? 4'hC : 4'h3;
                `TDP_SIZE_WORD: size_be = 4'hF;
                default:        size_be = 4'h0;
            endcase
        end
    endfunction

    // expand byte enables to a bit mask
    function [31:0] be_mask;
        input [3:0] be;
        begin
            be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // replicate narrow write data onto its byte lanes
    function [31:0] lane_data;
        input [1:0]  size;
        input [31:0] d;
        begin
            case (size)
                `TDP_SIZE_BYTE: lane_data = {4{d[7:0]}};
                `TDP_SIZE_HALF: lane_data = {2{d[15:0]}};
                default:        lane_data = d;
            endcase
        end
    endfunction

    // request taken only when enabled and request line low
    assign req_take     = DMA_PORT_ENABLE && !DMA_REQUEST_LOW_N;
    assign fifo_in_data = {DMA_WRITE_SELECT, DMA_ACCESS_SIZE,
                           DMA_ADDR_IN, DMA_WRITE_WORD};

    tdp_fifo #(
        .WIDTH (`TDP_REQ_W),
        .DEPTH (`TDP_FIFO_DEPTH),
        .AW    (`TDP_FIFO_AW)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RESET),
        .in_valid  (req_take),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (dma_go),
        .out_data  (fifo_out_data)
    );

    // fields of the request at the fifo head
    assign hd_write = fifo_out_data[60];
    assign hd_size  = fifo_out_data[59:58];
    assign hd_addr  = fifo_out_data[57:32];
    assign hd_data  = fifo_out_data[31:0];
    assign hd_index = hd_addr[`TDP_RAM_AW+1:2];
    assign hd_be    = size_be(hd_size, hd_addr[1:0]);
    assign hd_wmask = be_mask(hd_be);
    assign hd_wdata = lane_data(hd_size, hd_data);

    // both stall sources act identically on the core
    assign stall_cause = DMA_STALL_REQUEST || TRACE_BUFFER_FULL;
    // dma owns the ram whenever the core is not using it or is stalled
    assign dma_go      = fifo_out_valid && (CORE_STALL || !CORE_RAM_REQ);
    assign core_go     = CORE_RAM_REQ && !CORE_STALL;
    assign core_wmask  = be_mask(CORE_RAM_BE);

    // single-port ram: one access per cycle, dma or core
    always @(posedge SYS_CLK) begin
        if (dma_go) begin
            if (hd_write == `TDP_DIR_WRITE) begin
                ram[hd_index] <= (ram[hd_index] & ~hd_wmask) | (hd_wdata & hd_wmask);
            end
        end else if (core_go && CORE_RAM_WRITE) begin
            ram[CORE_RAM_ADDR] <= (ram[CORE_RAM_ADDR] & ~core_wmask)
                                  | (CORE_RAM_WDATA & core_wmask);
        end
    end

    // registered outputs: stall, ack, read data
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            REQ_ACCEPT     <= 1'b0;
            DMA_STALL_ACK  <= 1'b0;
            DMA_READ_WORD  <= {`TDP_DATA_W{1'b0}};
            DMA_READ_VALID <= 1'b0;
            CORE_STALL     <= 1'b0;
            CORE_RAM_RDATA <= {`TDP_DATA_W{1'b0}};
        end else begin
            REQ_ACCEPT     <= fifo_in_ready;
            CORE_STALL     <= stall_cause;
            DMA_STALL_ACK  <= stall_cause;
            DMA_READ_VALID <= dma_go && (hd_write == `TDP_DIR_READ);
            if (dma_go && (hd_write == `TDP_DIR_READ)) begin
                DMA_READ_WORD <= ram[hd_index];
            end
            if (core_go && !CORE_RAM_WRITE) begin
                CORE_RAM_RDATA <= ram[CORE_RAM_ADDR];
            end
        end
    end
endmodule // tdp_access_port

/* src/tdp_consts.vh */
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH
// dma port widths
`define TDP_ADDR_W        26
`define TDP_DATA_W        32
// data ram depth in words (addr bits 25:2 of which the low ones are used)
`define TDP_RAM_AW        10
`define TDP_RAM_DEPTH     1024
// access size encodings
`define TDP_SIZE_BYTE     2'h0
`define TDP_SIZE_HALF     2'h1
`define TDP_SIZE_WORD     2'h2
`define TDP_SIZE_RSVD     2'h3
// direction select
`define TDP_DIR_READ      1'h0
`define TDP_DIR_WRITE     1'h1
// request fifo
`define TDP_FIFO_DEPTH    8
`define TDP_FIFO_AW       3
// fifo entry: {write, size[1:0], addr[25:0], data[31:0]}
`define TDP_REQ_W         61
`endif

/* verification/tdp_access_port_asserts.sv */
`timescale 1ns/1ps
module tdp_port_chk (
    input wire        SYS_CLK,
    input wire        RESET,
    input wire        DMA_PORT_ENABLE,
    input wire        DMA_REQUEST_LOW_N,
    input wire        DMA_WRITE_SELECT,
    input wire        DMA_STALL_REQUEST,
    input wire        TRACE_BUFFER_FULL,
    input wire        CORE_RAM_REQ,
    input wire        REQ_ACCEPT,
    input wire        DMA_STALL_ACK,
    input wire [31:0] DMA_READ_WORD,
    input wire        DMA_READ_VALID,
    input wire        CORE_STALL
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    a_ack_on_wait: assert property ($rose(DMA_STALL_REQUEST) |=> DMA_STALL_ACK && CORE_STALL)
        else $error("stall request not answered");
    a_full_stalls: assert property (TRACE_BUFFER_FULL |=> CORE_STALL && DMA_STALL_ACK)
        else $error("trace full did not stall");
    a_ack_is_stall: assert property (DMA_STALL_ACK == CORE_STALL)
        else $error("ack differs from core stall");
    a_ack_drops: assert property (!DMA_STALL_REQUEST && !TRACE_BUFFER_FULL |=> !DMA_STALL_ACK)
        else $error("ack without stall cause");
    a_read_answer: assert property (DMA_PORT_ENABLE && !DMA_REQUEST_LOW_N
        && !DMA_WRITE_SELECT && REQ_ACCEPT && !CORE_RAM_REQ |-> ##[2:20] DMA_READ_VALID)
        else $error("read never answered");
    a_word_holds: assert property (!DMA_READ_VALID |-> $stable(DMA_READ_WORD))
        else $error("read word moved without valid");
    a_idle_quiet: assert property (!DMA_PORT_ENABLE [*8] |=> !DMA_READ_VALID)
        else $error("read data while port unused");
    a_accept_start: assert property ($fell(RESET) |-> !REQ_ACCEPT ##1 REQ_ACCEPT)
        else $error("accept not raised after reset");
endmodule // tdp_port_chk
bind tdp_access_port tdp_port_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .DMA_PORT_ENABLE(DMA_PORT_ENABLE), .DMA_REQUEST_LOW_N(DMA_REQUEST_LOW_N),
    .DMA_WRITE_SELECT(DMA_WRITE_SELECT), .DMA_STALL_REQUEST(DMA_STALL_REQUEST),
    .TRACE_BUFFER_FULL(TRACE_BUFFER_FULL), .CORE_RAM_REQ(CORE_RAM_REQ),
    .REQ_ACCEPT(REQ_ACCEPT), .DMA_STALL_ACK(DMA_STALL_ACK), .DMA_READ_WORD(DMA_READ_WORD),
    .DMA_READ_VALID(DMA_READ_VALID), .CORE_STALL(CORE_STALL));

/* verification/tdp_dma_master.sv */
`timescale 1ns/1ps
module tdp_dma_master (
    input  wire        clk,
    output reg         en = 1'h0,
    output reg         req_n = 1'h1,
    output reg  [25:0] addr = 26'h0,
    output reg         wr = 1'h0,
    output reg  [1:0]  size = 2'h0,
    output reg  [31:0] wdata = 32'h0,
    output reg         stall = 1'h0
);
    // one request, held for one clock edge whether or not that edge takes it
    task push(input w, input [1:0] s, input [25:0] a, input [31:0] d);
        begin
            en <= 1'h1;
            req_n <= 1'h0;
            wr <= w;
            size <= s;
            addr <= a & 26'hFFF;
            wdata <= d;
            @(posedge clk);
        end
    endtask
    // core stall request, a level held by the master until it lets go
    task hold_stall(input v);
        begin
            stall <= v;
        end
    endtask
    // port released: old address and data no longer shown, write select and size kept
    task idle;
        begin
            en <= 1'h0;
            req_n <= 1'h1;
            addr <= {14'h0, ~addr[11:0]};
            wdata <= ~wdata;
            @(posedge clk);
        end
    endtask
endmodule // tdp_dma_master

/* verification/tdp_access_port_tb_top.sv */
`timescale 1ns/1ps
module tdp_access_port_tb_top;
    reg         clk = 1'h0, rst = 1'h1, creq = 1'h0, full = 1'h0;
    wire        en, rqn, wr, acc, ack, rv, cst, stl;
    wire [25:0] adr;
    wire [1:0]  sz;
    wire [31:0] wd, rw, crd;
    integer     mismatches = 0, n_tests = 0, i, j;
    reg  [31:0] got [$];
    tdp_access_port dut (.SYS_CLK(clk), .RESET(rst), .DMA_PORT_ENABLE(en),
        .DMA_REQUEST_LOW_N(rqn), .DMA_ADDR_IN(adr), .DMA_WRITE_SELECT(wr),
        .DMA_ACCESS_SIZE(sz), .DMA_WRITE_WORD(wd), .DMA_STALL_REQUEST(stl),
        .TRACE_BUFFER_FULL(full), .CORE_RAM_REQ(creq), .CORE_RAM_WRITE(1'h0),
        .CORE_RAM_ADDR(10'h4), .CORE_RAM_BE(4'h0), .CORE_RAM_WDATA(32'h0),
        .REQ_ACCEPT(acc), .DMA_STALL_ACK(ack), .DMA_READ_WORD(rw),
        .DMA_READ_VALID(rv), .CORE_STALL(cst), .CORE_RAM_RDATA(crd));
    tdp_dma_master mst (.clk(clk), .en(en), .req_n(rqn), .addr(adr), .wr(wr),
        .size(sz), .wdata(wd), .stall(stl));
    always #10 clk = ~clk;
    // log every read word in arrival order
    always @(posedge clk) if (rv === 1'h1) got.push_back(rw);
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("mismatches %0d n_tests %0d", mismatches, n_tests);
            if (mismatches == 0 && n_tests > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task wt(input integer n);
        begin
            for (j = 0; j < 40 && got.size() < n; j = j + 1) @(posedge clk);
            if (got.size() < n) begin
                mismatches = mismatches + 1;
                end_of_test;
            end
        end
    endtask
    task rd(input [25:0] a, input [31:0] e);
        begin
            got.delete();
            mst.push(1'h0, 2'h3, a, 32'h0);
            mst.idle;
            wt(1);
            chk(got[0], e);
        end
    endtask
    // every write size, reserved size writes nothing
    task t_sizes;
        begin
            mst.push(1'h1, 2'h2, 26'h10, 32'h11223344);
            mst.push(1'h1, 2'h0, 26'h11, 32'h55AA);
            mst.push(1'h1, 2'h1, 26'h12, 32'hBEEF);
            mst.push(1'h1, 2'h3, 26'h10, 32'h0);
            mst.push(1'h1, 2'h2, 26'hA0, 32'h5);
            mst.idle;
            rd(26'h10, 32'hBEEFAA44);
        end
    endtask
    // core holds the ram: fifo fills and refuses the ninth
    task t_full;
        begin
            creq <= 1'h1;
            @(posedge clk);
            for (i = 0; i < 9; i = i + 1)
                mst.push(1'h1, 2'h2, 26'(32'h80 + i * 4), 32'hA0 + i);
            mst.idle;
            chk({31'h0, acc}, 32'h0);
            chk(crd, 32'hBEEFAA44);
            creq <= 1'h0;
            // full fifo refuses even while popping: wait until room is reported
            repeat (3) @(posedge clk);
            chk({31'h0, acc}, 32'h1);
            rd(26'h9C, 32'hA7);
            rd(26'hA0, 32'h5);
            got.delete();
            mst.push(1'h0, 2'h0, 26'h80, 32'h0);
            mst.push(1'h0, 2'h1, 26'h84, 32'h0);
            mst.push(1'h0, 2'h2, 26'h10, 32'h0);
            mst.idle;
            wt(3);
            chk(got[0], 32'hA0);
            chk(got[1], 32'hA1);
            chk(got[2], 32'hBEEFAA44);
        end
    endtask
    // both stall causes stall the core; dma then reads past the core
    task t_stall;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                creq <= 1'h1;
                if (i == 0) mst.hold_stall(1'h1);
                else full <= 1'h1;
                repeat (2) @(posedge clk);
                chk({30'h0, ack, cst}, 32'h3);
                rd(26'h84, 32'hA1);
                mst.hold_stall(1'h0);
                full <= 1'h0;
                creq <= 1'h0;
                repeat (2) @(posedge clk);
                chk({30'h0, ack, cst}, 32'h0);
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        t_sizes;
        t_full;
        t_stall;
        end_of_test;
    end
endmodule // tdp_access_port_tb_top
